/* File: flash_erase_checker.sv */
// Purpose: timing relations of the erase sequencer
// Assumes: one clock domain, both ends at 20 MHz
// Notes: sees link pins and device status levels
`timescale 1ns/1ns
module flash_erase_checker #(
	parameter int unsigned SUSPEND_US = 20 // suspend latency
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic busy_r,
	input wire logic write_enable_latch_r,
	input wire logic suspend_flag_r,
	input wire logic erase_go_r,
	input wire logic erase_done_r,
	input wire flash_erase_pkg::op_kind_t erase_kind_r
);
	// two spare cycles cover the accept edge
	localparam int SUS_MAX = SUSPEND_US * 20 + 2;
	// chip erase in flight, from its start pulse to its done pulse
	logic chip_run;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			chip_run <= 1'b0;
		end else if (erase_go_r) begin
			chip_run <= erase_kind_r == flash_erase_pkg::OP_CHIP;
		end else if (erase_done_r) begin
			chip_run <= 1'b0;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	chk_go_wel: assert property (erase_go_r |-> write_enable_latch_r && busy_r)
		else $error("erase started without latch");
	chk_go_after_cs: assert property (erase_go_r |-> cs_n)
		else $error("erase started inside a frame");
	chk_done_clear: assert property (erase_done_r |-> !busy_r && !write_enable_latch_r)
		else $error("busy or latch left after erase");
	chk_done_was_busy: assert property (erase_done_r |-> $past(busy_r))
		else $error("erase ended while idle");
	chk_sus_busy: assert property ($rose(suspend_flag_r) |-> busy_r && !chip_run)
		else $error("suspend taken while idle or chip erase");
	chk_sus_drop: assert property ($rose(suspend_flag_r) |-> ##[0:SUS_MAX] !busy_r)
		else $error("busy not dropped after suspend");
	chk_resume_busy: assert property ($fell(suspend_flag_r) |-> ##[0:3] busy_r)
		else $error("busy not back after resume");
	chk_sclk_idle: assert property (cs_n |-> !sclk)
		else $error("serial clock high outside frame");
endmodule : flash_erase_checker

/* File: flash_erase_device.sv */
// Purpose: erase and suspend command sequencer of a serial flash device
// Assumes: link pins come from another domain; memory array sits outside
// Notes: erase_go/erase_done tell the array owner what to clear to FFh
`timescale 1ns/1ns
`include "flash_erase_regs.svh"
module flash_erase_device #(
	parameter int unsigned SECTOR_ERASE_US = 100, // sector erase time
	parameter int unsigned SMALL_BLOCK_ERASE_US = 200, // small_block_erase_time
	parameter int unsigned BLOCK_ERASE_US = 300, // 64KB erase time
	parameter int unsigned CHIP_ERASE_US = 2000, // chip erase time
	parameter int unsigned PROGRAM_US = 50, // page program time
	parameter int unsigned SUSPEND_US = 20 // max suspend latency
) (
	input wire logic clk,
	input wire logic reset_n,
	flash_link_if.dev link,
	input wire logic addr4_mode,
	input wire logic [3:0] block_protect_bits,
	input wire logic protect_top_bottom,
	input wire logic protect_complement,
	input wire logic lock_hit,
	input wire logic lock_any,
	input wire logic prog_start,
	output logic [31:0] lock_query_addr_r,
	output logic busy_r,
	output logic write_enable_latch_r,
	output logic suspend_flag_r,
	output logic erase_go_r,
	output flash_erase_pkg::op_kind_t erase_kind_r,
	output logic [31:0] erase_addr_r,
	output logic erase_done_r,
	output logic wrsr_blocked_r,
	output logic program_blocked_r
);
	// ------------------------------------------------------------------------
	// timing counts
	// ------------------------------------------------------------------------
	localparam int unsigned SE_CYC = SECTOR_ERASE_US * `CLK_MHZ;
	localparam int unsigned B32_CYC = SMALL_BLOCK_ERASE_US * `CLK_MHZ;
	localparam int unsigned B64_CYC = BLOCK_ERASE_US * `CLK_MHZ;
	localparam int unsigned CE_CYC = CHIP_ERASE_US * `CLK_MHZ;
	localparam int unsigned PP_CYC = PROGRAM_US * `CLK_MHZ;
	localparam int unsigned SUS_CYC = SUSPEND_US * `CLK_MHZ;
	// busy comes back one cycle after resume, well inside this bound
	localparam int unsigned RESUME_CYC = `RESUME_BUSY_NS / `CLK_PERIOD_NS;

	// ------------------------------------------------------------------------
	// functions
	// ------------------------------------------------------------------------
	// erase kind from opcode
	function automatic flash_erase_pkg::op_kind_t kind_of(input logic [7:0] op);
		unique case (op)
			`OP_SE, `OP_SE4: kind_of = flash_erase_pkg::OP_SECTOR;
			`OP_BE32: kind_of = flash_erase_pkg::OP_BLK32;
			`OP_BE64, `OP_BE64_4: kind_of = flash_erase_pkg::OP_BLK64;
			`OP_CE, `OP_CE_B: kind_of = flash_erase_pkg::OP_CHIP;
			default: kind_of = flash_erase_pkg::OP_NONE;
		endcase
	endfunction : kind_of

	// exact frame length an opcode needs; zero for opcodes not handled here
	function automatic logic [6:0] need_bits(input logic [7:0] op, input logic a4);
		unique case (op)
			`OP_SE4, `OP_BE64_4: need_bits = `BITS_A4;
			`OP_SE, `OP_BE32, `OP_BE64: need_bits = a4 ? `BITS_A4 : `BITS_A3;
			`OP_CE, `OP_CE_B, `OP_WREN, `OP_WRDI,
			`OP_SUSPEND, `OP_RESUME: need_bits = `BITS_OP;
			default: need_bits = 7'h00;
		endcase
	endfunction : need_bits

	// protected block count set by the protect bits
	function automatic logic [9:0] prot_count(input logic [3:0] bp);
		if (bp == 4'h0) begin
			prot_count = 10'h000;
		end else if (bp >= 4'hA) begin
			prot_count = `NUM_BLOCKS;
		end else begin
			prot_count = 10'(10'h001 << (bp - 4'h1));
		end
	endfunction : prot_count

	// ------------------------------------------------------------------------
	// link synchronisers
	// ------------------------------------------------------------------------
	logic cs_s1, cs_s2, cs_s3; // chip select chain, s3 for edges
	logic sclk_s1, sclk_s2, sclk_s3; // serial clock chain
	logic mosi_s1, mosi_s2; // data chain
	logic miso_r; // device data out
	logic [7:0] status; // status byte shifted out on reads

	// two flops per pin plus a third on chip select and serial clock; edges are taken from s2 against s3 only
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			{cs_s1, cs_s2, cs_s3} <= 3'h7;
			{sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
			{mosi_s1, mosi_s2} <= 2'h0;
		end else begin
			{cs_s1, cs_s2, cs_s3} <= {link.cs_n, cs_s1, cs_s2};
			{sclk_s1, sclk_s2, sclk_s3} <= {link.sclk, sclk_s1, sclk_s2};
			{mosi_s1, mosi_s2} <= {link.mosi, mosi_s1};
		end
	end

	logic sclk_rise, sclk_fall, cs_rise, selected;
	assign sclk_rise = sclk_s2 & ~sclk_s3;
	assign sclk_fall = ~sclk_s2 & sclk_s3;
	assign cs_rise = cs_s2 & ~cs_s3;
	assign selected = ~cs_s2;
	assign link.miso = miso_r;

	// ------------------------------------------------------------------------
	// frame capture
	// ------------------------------------------------------------------------
	logic [6:0] bitcnt_r; // bits seen this frame, saturating
	logic [39:0] shift_r; // opcode then address, newest bit at 0
	logic [7:0] opcode_r; // first byte of the frame

	// capture on serial clock rise while selected; a new frame restarts
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bitcnt_r <= 7'h00;
			shift_r <= 40'h0;
			opcode_r <= 8'h00;
		end else if (!selected) begin
			bitcnt_r <= 7'h00;
		end else if (sclk_rise) begin
			shift_r <= {shift_r[38:0], mosi_s2};
			if (bitcnt_r != `BITS_MAX) begin
				bitcnt_r <= bitcnt_r + 7'h01;
			end
			if (bitcnt_r == (`BITS_OP - 7'h01)) begin
				opcode_r <= {shift_r[6:0], mosi_s2};
			end
		end
	end

	// status out on falling edges; long reads keep sending the busy bit at saturation
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			miso_r <= 1'b0;
		end else if (selected && sclk_fall && opcode_r == `OP_RDSR &&
			bitcnt_r >= `BITS_OP) begin
			miso_r <= status[~bitcnt_r[2:0]];
		end
	end

	// ------------------------------------------------------------------------
	// command decode at chip select rise
	// ------------------------------------------------------------------------
	logic four, exec, is_erase, prot, any_prot, in_range;
	logic start_erase, start_prog, suspend_ok, resume_ok, wren, wrdi;
	logic [31:0] addr_now;
	logic [9:0] pcount, blk;
	flash_erase_pkg::op_kind_t kind_now, op_kind_r;

	always_comb begin
		status = 8'h00;
		status[`ST_BUSY] = busy_r;
		status[`ST_WEL] = write_enable_latch_r;
		status[`ST_SUS] = suspend_flag_r;
		four = addr4_mode || opcode_r == `OP_SE4 || opcode_r == `OP_BE64_4;
		addr_now = four ? shift_r[31:0] : {8'h00, shift_r[23:0]};
		// frame must end exactly on its last bit
		exec = cs_rise && need_bits(opcode_r, addr4_mode) != 7'h00 &&
			bitcnt_r == need_bits(opcode_r, addr4_mode);
		kind_now = kind_of(opcode_r);
		is_erase = kind_now != flash_erase_pkg::OP_NONE;
		pcount = prot_count(block_protect_bits);
		blk = {1'b0, addr_now[`BLK_LSB +: 9]};
		in_range = protect_top_bottom ? (blk < pcount) : (blk >= (`NUM_BLOCKS - pcount));
		any_prot = protect_complement ? (pcount != `NUM_BLOCKS) : (pcount != 10'h000);
		prot = (kind_now == flash_erase_pkg::OP_CHIP) ? (any_prot || lock_any) :
			((in_range ^ protect_complement) || lock_hit);
		// any suspend blocks new erases; refusal touches nothing
		start_erase = exec && is_erase && !busy_r && write_enable_latch_r &&
			!suspend_flag_r && !prot;
		start_prog = prog_start && !busy_r && write_enable_latch_r && !suspend_flag_r;
		// chip erase and idle state cannot be suspended
		suspend_ok = exec && opcode_r == `OP_SUSPEND && busy_r && !suspend_flag_r &&
			op_kind_r != flash_erase_pkg::OP_CHIP && op_kind_r != flash_erase_pkg::OP_NONE;
		resume_ok = exec && opcode_r == `OP_RESUME && suspend_flag_r && !busy_r;
		wren = exec && opcode_r == `OP_WREN && !busy_r;
		wrdi = exec && opcode_r == `OP_WRDI && !busy_r;
	end

	// ------------------------------------------------------------------------
	// self-timed engine
	// ------------------------------------------------------------------------
	logic [31:0] remain_r; // cycles left in the running operation
	logic [31:0] sus_cnt_r; // cycles left until busy drops on suspend
	logic running, done;
	assign running = busy_r && !suspend_flag_r;
	assign done = running && remain_r == 32'h1;

	// operation kind and remaining time; frozen while suspended
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			op_kind_r <= flash_erase_pkg::OP_NONE;
			remain_r <= 32'h0;
		end else if (start_erase) begin
			op_kind_r <= kind_now;
			unique case (kind_now)
				flash_erase_pkg::OP_SECTOR: remain_r <= 32'(SE_CYC);
				flash_erase_pkg::OP_BLK32: remain_r <= 32'(B32_CYC);
				flash_erase_pkg::OP_BLK64: remain_r <= 32'(B64_CYC);
				default: remain_r <= 32'(CE_CYC);
			endcase
		end else if (start_prog) begin
			op_kind_r <= flash_erase_pkg::OP_PROGRAM;
			remain_r <= 32'(PP_CYC);
		end else if (done) begin
			op_kind_r <= flash_erase_pkg::OP_NONE;
			remain_r <= 32'h0;
		end else if (running) begin
			remain_r <= remain_r - 32'h1;
		end
	end

	// busy: up at start and resume, down at end or after the suspend latency
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			busy_r <= 1'b0;
			sus_cnt_r <= 32'h0;
		end else if (start_erase || start_prog) begin
			busy_r <= 1'b1;
		end else if (resume_ok) begin
			busy_r <= 1'b1; // within RESUME_CYC
		end else if (suspend_ok && !done) begin
			// a suspend landing on the last cycle is dropped; nothing is left to freeze
			sus_cnt_r <= 32'(SUS_CYC);
		end else if (done) begin
			busy_r <= 1'b0;
		end else if (sus_cnt_r != 32'h0) begin
			sus_cnt_r <= sus_cnt_r - 32'h1;
			if (sus_cnt_r == 32'h1) begin
				busy_r <= 1'b0;
			end
		end
	end

	// suspend flag: set at once, cleared at once on resume; reset is power loss
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			suspend_flag_r <= 1'b0;
		end else if (suspend_ok && !done) begin
			suspend_flag_r <= 1'b1;
		end else if (resume_ok) begin
			suspend_flag_r <= 1'b0;
		end
	end

	// write enable latch; never set and cleared in one cycle since busy splits them
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			write_enable_latch_r <= 1'b0;
		end else if (wren) begin
			write_enable_latch_r <= 1'b1;
		end else if (wrdi || done) begin
			write_enable_latch_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// array side and blocking outputs
	// ------------------------------------------------------------------------
	// erase_go names the aligned region; array owner fills it with FFh
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			erase_go_r <= 1'b0;
			erase_kind_r <= flash_erase_pkg::OP_NONE;
			erase_addr_r <= 32'h0;
			erase_done_r <= 1'b0;
			lock_query_addr_r <= 32'h0;
			wrsr_blocked_r <= 1'b0;
			program_blocked_r <= 1'b0;
		end else begin
			erase_go_r <= start_erase;
			lock_query_addr_r <= addr_now;
			if (start_erase) begin
				erase_kind_r <= kind_now;
				unique case (kind_now)
					flash_erase_pkg::OP_SECTOR: erase_addr_r <= addr_now & `MASK_4K;
					flash_erase_pkg::OP_BLK32: erase_addr_r <= addr_now & `MASK_32K;
					flash_erase_pkg::OP_BLK64: erase_addr_r <= addr_now & `MASK_64K;
					default: erase_addr_r <= 32'h0;
				endcase
			end
			erase_done_r <= done && op_kind_r != flash_erase_pkg::OP_PROGRAM;
			// other regions stay usable by outside engines
			wrsr_blocked_r <= suspend_flag_r;
			program_blocked_r <= suspend_flag_r && op_kind_r == flash_erase_pkg::OP_PROGRAM;
		end
	end
endmodule : flash_erase_device

/* File: flash_erase_host.sv */
// Purpose: host end issuing erase, suspend, resume and status frames
// Assumes: device samples on serial clock rise and shifts on fall
// Notes: makes the serial clock from clk, eight clocks per bit
`timescale 1ns/1ns
`include "flash_erase_regs.svh"
module flash_erase_host #(
	parameter int unsigned SUSPEND_US = 20 // guard after a resume
) (
	input wire logic clk,
	input wire logic reset_n,
	flash_link_if.host link,
	input wire logic addr4_mode,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_opcode,
	input wire logic [31:0] cmd_addr,
	output logic cmd_ready_r,
	output logic cmd_refused_r,
	output logic status_valid_r,
	output logic [7:0] status_byte_r
);
	localparam int unsigned SUS_CYC = SUSPEND_US * `CLK_MHZ;

	// ------------------------------------------------------------------------
	// functions
	// ------------------------------------------------------------------------
	// frame bits for an opcode, read byte included
	function automatic logic [6:0] frame_bits(input logic [7:0] op, input logic a4);
		unique case (op)
			`OP_SE4, `OP_BE64_4: frame_bits = `BITS_A4;
			`OP_SE, `OP_BE32, `OP_BE64: frame_bits = a4 ? `BITS_A4 : `BITS_A3;
			`OP_RDSR: frame_bits = `BITS_OP + `BITS_OP;
			default: frame_bits = `BITS_OP;
		endcase
	endfunction : frame_bits

	function automatic logic is_erase_op(input logic [7:0] op);
		is_erase_op = op == `OP_SE || op == `OP_SE4 || op == `OP_BE32 || op == `OP_BE64 ||
			op == `OP_BE64_4 || op == `OP_CE || op == `OP_CE_B || op == `OP_ERASE_SEC;
	endfunction : is_erase_op

	function automatic logic is_prog_op(input logic [7:0] op);
		is_prog_op = op == `OP_PROG || op == `OP_QPROG || op == `OP_PROG_SEC ||
			op == `OP_PROG4 || op == `OP_QPROG4;
	endfunction : is_prog_op

	// ------------------------------------------------------------------------
	// suspend bookkeeping
	// ------------------------------------------------------------------------
	logic miso_s1, miso_s2; // device data, two flops
	logic last_erase_r, sus_erase_r, sus_prog_r; // what is suspended
	logic [31:0] guard_r; // cycles before a new suspend is legal
	logic forbid, accept;
	flash_erase_pkg::host_state_t state_r;

	always_comb begin
		forbid = (sus_erase_r && (cmd_opcode == `OP_WRSR || is_erase_op(cmd_opcode))) ||
			(sus_prog_r && (cmd_opcode == `OP_WRSR || is_prog_op(cmd_opcode))) ||
			(cmd_opcode == `OP_SUSPEND && guard_r != 32'h0);
		accept = cmd_valid && cmd_ready_r;
	end

	// track issued long operations and suspend state
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			{miso_s1, miso_s2} <= 2'h0;
			last_erase_r <= 1'b0;
			sus_erase_r <= 1'b0;
			sus_prog_r <= 1'b0;
			guard_r <= 32'h0;
		end else begin
			{miso_s1, miso_s2} <= {link.miso, miso_s1};
			if (accept && !forbid && cmd_opcode == `OP_RESUME) begin
				guard_r <= 32'(SUS_CYC);
			end else if (guard_r != 32'h0) begin
				guard_r <= guard_r - 32'h1;
			end
			if (accept && !forbid) begin
				if (is_erase_op(cmd_opcode)) begin
					last_erase_r <= 1'b1;
				end else if (is_prog_op(cmd_opcode)) begin
					last_erase_r <= 1'b0;
				end
				if (cmd_opcode == `OP_SUSPEND) begin
					sus_erase_r <= last_erase_r;
					sus_prog_r <= !last_erase_r;
				end else if (cmd_opcode == `OP_RESUME) begin
					sus_erase_r <= 1'b0;
					sus_prog_r <= 1'b0;
				end
			end
			// a status read showing no suspend ends a stale belief, e.g. after chip erase
			if (status_valid_r && !status_byte_r[`ST_SUS]) begin
				sus_erase_r <= 1'b0;
				sus_prog_r <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------------
	// frame sequencer
	// ------------------------------------------------------------------------
	logic cs_n_r, sclk_r, mosi_r;
	logic [39:0] sr_r; // bits still to send, msb first
	logic [6:0] nbits_r; // cells left in the frame
	logic [2:0] phase_r; // position inside one bit cell
	logic reading_r; // frame ends with a status byte
	logic [7:0] rx_r;
	assign link.cs_n = cs_n_r;
	assign link.sclk = sclk_r;
	assign link.mosi = mosi_r;

	// one cell: drive at 0, rise at 4, sample at 7, fall at next 0
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= flash_erase_pkg::H_IDLE;
			{cs_n_r, sclk_r, mosi_r} <= 3'h4;
			sr_r <= 40'h0;
			nbits_r <= 7'h00;
			phase_r <= 3'h0;
			reading_r <= 1'b0;
			rx_r <= 8'h00;
			cmd_ready_r <= 1'b0;
			cmd_refused_r <= 1'b0;
			status_valid_r <= 1'b0;
			status_byte_r <= 8'h00;
		end else begin
			cmd_refused_r <= accept && forbid;
			status_valid_r <= 1'b0;
			unique case (state_r)
				flash_erase_pkg::H_IDLE: begin
					cmd_ready_r <= !accept;
					if (accept && !forbid) begin
						state_r <= flash_erase_pkg::H_CELL;
						cs_n_r <= 1'b0;
						phase_r <= `CELL_DRIVE;
						nbits_r <= frame_bits(cmd_opcode, addr4_mode);
						reading_r <= cmd_opcode == `OP_RDSR;
						if (frame_bits(cmd_opcode, addr4_mode) == `BITS_A3) begin
							sr_r <= {cmd_opcode, cmd_addr[23:0], 8'h00};
						end else begin
							sr_r <= {cmd_opcode, cmd_addr};
						end
					end
				end
				flash_erase_pkg::H_CELL: begin
					phase_r <= phase_r + 3'h1;
					if (phase_r == `CELL_DRIVE) begin
						sclk_r <= 1'b0;
						mosi_r <= sr_r[39];
						sr_r <= {sr_r[38:0], 1'b0};
					end else if (phase_r == `CELL_RISE) begin
						sclk_r <= 1'b1;
					end else if (phase_r == `CELL_LAST) begin
						if (reading_r && nbits_r <= `BITS_OP) begin
							rx_r <= {rx_r[6:0], miso_s2};
						end
						nbits_r <= nbits_r - 7'h01;
						if (nbits_r == 7'h01) begin
							state_r <= flash_erase_pkg::H_END;
						end
					end
				end
				default: begin
					// chip select rises right after the last bit
					{cs_n_r, sclk_r, mosi_r} <= 3'h4;
					phase_r <= phase_r + 3'h1;
					if (phase_r == `CELL_DRIVE) begin
						status_valid_r <= reading_r;
						status_byte_r <= rx_r;
					end
					if (phase_r == `CELL_LAST) begin
						state_r <= flash_erase_pkg::H_IDLE;
						cmd_ready_r <= 1'b1;
					end
				end
			endcase
		end
	end
endmodule : flash_erase_host

/* File: flash_erase_pkg.sv */
// Purpose: shared types of the erase sequencer ends
// Assumes: nothing beyond the constants header
// Notes: types only
package flash_erase_pkg;
	// kind of self-timed operation in the array
	typedef enum logic [2:0] {
		OP_NONE, OP_SECTOR, OP_BLK32, OP_BLK64, OP_CHIP, OP_PROGRAM
	} op_kind_t;
	// host frame sequencer
	typedef enum logic [1:0] {H_IDLE, H_CELL, H_END} host_state_t;
endpackage : flash_erase_pkg

/* File: flash_erase_regs.svh */
// Purpose: opcodes, status layout and timing figures of the erase sequencer
// Assumes: 20 MHz system clock on both ends
// Notes: definitions only
`ifndef FLASH_ERASE_REGS_SVH
`define FLASH_ERASE_REGS_SVH

// ----------------------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------------------
`define OP_WRSR 8'h01
`define OP_PROG 8'h02
`define OP_WRDI 8'h04
`define OP_RDSR 8'h05
`define OP_WREN 8'h06
`define OP_PROG4 8'h12
`define OP_SE 8'h20
`define OP_SE4 8'h21
`define OP_QPROG 8'h32
`define OP_QPROG4 8'h34
`define OP_PROG_SEC 8'h42
`define OP_ERASE_SEC 8'h44
`define OP_BE32 8'h52
`define OP_CE_B 8'h60
`define OP_SUSPEND 8'h75
`define OP_RESUME 8'h7A
`define OP_CE 8'hC7
`define OP_BE64 8'hD8
`define OP_BE64_4 8'hDC

// ----------------------------------------------------------------------------
// status byte returned by the status read
// ----------------------------------------------------------------------------
`define ST_BUSY 0
`define ST_WEL 1
`define ST_SUS 7

// ----------------------------------------------------------------------------
// frame lengths in bits and address masks
// ----------------------------------------------------------------------------
`define BITS_OP 7'h08
`define BITS_A3 7'h20
`define BITS_A4 7'h28
`define BITS_MAX 7'h7F
`define MASK_4K 32'hFFFF_F000
`define MASK_32K 32'hFFFF_8000
`define MASK_64K 32'hFFFF_0000
`define NUM_BLOCKS 10'h200
`define BLK_LSB 16

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CLK_MHZ 20
`define CLK_PERIOD_NS 50
`define RESUME_BUSY_NS 200
`define CELL_DRIVE 3'h0
`define CELL_RISE 3'h4
`define CELL_LAST 3'h7

`endif

/* File: flash_link_if.sv */
// Purpose: single-lane serial link between flash host and flash device
// Assumes: host makes the serial clock, mode 0 (idle low)
// Notes: no two-way pins in single-lane use
`timescale 1ns/1ns
interface flash_link_if;
	logic cs_n; // chip select, active low
	logic sclk; // serial clock from host
	logic mosi; // host to device data
	logic miso; // device to host data
	modport dev(input cs_n, input sclk, input mosi, output miso);
	modport host(output cs_n, output sclk, output mosi, input miso);
endinterface : flash_link_if

/* File: serial_flash_erase_suspend_tb.sv */
// Purpose: host and device ends joined, driven from the host user port
// Assumes: shortened erase times, default suspend latency
// Notes: addresses from a seeded xorshift
`timescale 1ns/1ns
`include "flash_erase_regs.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module serial_flash_erase_suspend_tb;
	logic clk, reset_n, a4, cv, rdy, rfs, sv, busy, write_enable_latch, suspend_flag, go, done;
	logic tbm, cmpl, lh, la, ps, wb, pb;
	logic [3:0] bp;
	logic [7:0] op, sb;
	logic [31:0] ad, eq, st, lq, ex;
	flash_erase_pkg::op_kind_t kind;
	int n_mismatch, num_checks, n_go, n_ref, cyc, ng, n_sv;
	logic [7:0] ops [7] = '{8'h20, 8'h21, 8'h52, 8'hD8, 8'hDC, 8'hC7, 8'h60};
	flash_link_if lnk();
	flash_erase_device #(.SECTOR_ERASE_US(1), .SMALL_BLOCK_ERASE_US(1), .BLOCK_ERASE_US(30),
		.CHIP_ERASE_US(40)) i_flash_erase_device (.clk(clk), .reset_n(reset_n), .link(lnk.dev),
		.addr4_mode(a4), .block_protect_bits(bp), .protect_top_bottom(tbm),
		.protect_complement(cmpl), .lock_hit(lh), .lock_any(la), .prog_start(ps),
		.lock_query_addr_r(lq), .busy_r(busy), .write_enable_latch_r(write_enable_latch),
		.suspend_flag_r(suspend_flag), .erase_go_r(go), .erase_kind_r(kind), .erase_addr_r(eq),
		.erase_done_r(done), .wrsr_blocked_r(wb), .program_blocked_r(pb));
	flash_erase_host i_flash_erase_host (.clk(clk), .reset_n(reset_n),
		.link(lnk.host), .addr4_mode(a4), .cmd_valid(cv), .cmd_opcode(op), .cmd_addr(ad),
		.cmd_ready_r(rdy), .cmd_refused_r(rfs), .status_valid_r(sv), .status_byte_r(sb));
	flash_erase_checker i_flash_erase_checker (.clk(clk),
		.reset_n(reset_n), .cs_n(lnk.cs_n), .sclk(lnk.sclk), .busy_r(busy),
		.write_enable_latch_r(write_enable_latch), .suspend_flag_r(suspend_flag), .erase_go_r(go),
		.erase_done_r(done), .erase_kind_r(kind));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs
	// expected kind and aligned address of an erase
	function automatic flash_erase_pkg::op_kind_t ek(input logic [7:0] o);
		case (o)
			8'h20, 8'h21: return flash_erase_pkg::OP_SECTOR;
			8'h52: return flash_erase_pkg::OP_BLK32;
			8'hD8, 8'hDC: return flash_erase_pkg::OP_BLK64;
			default: return flash_erase_pkg::OP_CHIP;
		endcase
	endfunction : ek
	function automatic logic [31:0] em(input logic [7:0] o, input logic [31:0] a);
		case (o)
			8'h20, 8'h21: return a & `MASK_4K;
			8'h52: return a & `MASK_32K;
			8'hD8, 8'hDC: return a & `MASK_64K;
			default: return 32'h0;
		endcase
	endfunction : em
	// request held from a falling edge until taken
	task automatic send(input logic [7:0] o, input logic [31:0] a);
		while (rdy !== 1'b1) @(negedge clk);
		op = o;
		ad = a;
		cv = 1'b1;
		@(negedge clk);
		cv = 1'b0;
		while (rdy !== 1'b1) @(negedge clk);
	endtask : send
	task automatic idle();
		while (busy !== 1'b0) @(negedge clk);
	endtask : idle
	// latch set, then the erase itself at the given address
	task automatic erase(input logic [7:0] o, input logic [31:0] a);
		ng = n_go;
		send(8'h06, 32'h0);
		send(o, a);
	endtask : erase
	task automatic give_verdict();
		$display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : give_verdict
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// event counters and hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (go === 1'b1) n_go <= n_go + 1;
		if (rfs === 1'b1) n_ref <= n_ref + 1;
		if (sv === 1'b1) n_sv <= n_sv + 1;
		if (cyc == 60000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	initial begin
		reset_n = 1'b0;
		cv = 1'b0;
		op = 8'h00;
		ad = 32'h0;
		a4 = 1'b0;
		bp = 4'h0;
		{tbm, cmpl, lh, la, ps} = 5'h00;
		st = 32'h0000_5267;
		repeat (20) @(negedge clk);
		reset_n = 1'b1;
		ng = n_go;
		send(8'h20, 32'h0000_1000);
		repeat (40) @(negedge clk);
		`CHK(n_go, ng)
		`CHK(busy, 1'b0)
		for (int m = 0; m < 2; m++) begin
			a4 = m[0];
			foreach (ops[i]) begin
				st = xs(st);
				ex = (a4 || ops[i] inside {8'h21, 8'hDC}) ? st : st & 32'h00FF_FFFF;
				erase(ops[i], st);
				idle();
				`CHK(n_go, ng + 1)
				`CHK(kind, ek(ops[i]))
				`CHK(eq, em(ops[i], ex))
				if (ek(ops[i]) != flash_erase_pkg::OP_CHIP) `CHK(lq, ex)
				`CHK(write_enable_latch, 1'b0)
			end
		end
		// full protection: refused, latch kept
		bp = 4'hF;
		erase(8'h20, st);
		repeat (40) @(negedge clk);
		`CHK(n_go, ng)
		`CHK(write_enable_latch, 1'b1)
		// bottom block only, then all but it, then one lock, then any lock
		{bp, tbm} = 5'h03;
		erase(8'h20, 32'h0000_F000);
		`CHK(n_go, ng)
		cmpl = 1'b1;
		send(8'h20, 32'h0000_F000);
		idle();
		`CHK(n_go, ng + 1)
		{bp, tbm, cmpl, lh} = 7'h01;
		erase(8'h52, st);
		`CHK(n_go, ng)
		{lh, la} = 2'b01;
		erase(8'h60, 32'h0);
		`CHK(n_go, ng)
		la = 1'b0;
		erase(8'hD8, st);
		send(8'h75, 32'h0);
		`CHK(suspend_flag, 1'b1)
		idle();
		send(8'h05, 32'h0);
		`CHK(sb, 8'h82)
		ng = n_ref;
		send(8'h20, st);
		send(8'h01, 32'h0);
		`CHK(n_ref, ng + 2)
		send(8'h7A, 32'h0);
		`CHK({suspend_flag, busy}, 2'b01)
		idle();
		erase(8'hC7, 32'h0);
		send(8'h75, 32'h0);
		`CHK({suspend_flag, busy}, 2'b01)
		send(8'h05, 32'h0);
		`CHK(sb, 8'h03)
		idle();
		// an outside page program, suspended and resumed
		send(8'h06, 32'h0);
		ps = 1'b1;
		@(negedge clk);
		ps = 1'b0;
		send(8'h75, 32'h0);
		idle();
		`CHK({pb, wb, suspend_flag}, 3'h7)
		send(8'h7A, 32'h0);
		idle();
		`CHK({pb, wb, write_enable_latch}, 3'h0)
		`CHK(n_sv, 2)
		// reset while suspended stands for power loss
		erase(8'hD8, st);
		send(8'h75, 32'h0);
		`CHK(suspend_flag, 1'b1)
		reset_n = 1'b0;
		repeat (3) @(negedge clk);
		`CHK(suspend_flag, 1'b0)
		give_verdict();
	end
endmodule : serial_flash_erase_suspend_tb
